// File: include/select_pkg.sv
/*
 package for the unit select and motor control qualifier of a disk drive.
 assumes one 100 MHz system clock and an active high asynchronous reset.
*/
//
// Function
// RQ1 - motor inputs drive spindle; polarity chosen by low or high jumper
// RQ2 - four separate unit select inputs address up to four drives
// RQ3 - matching select low activates electronics, steps, read and write
// RQ4 - matching select high ignores inputs and disables all status outputs; code keeps driving head_one_out and media_change_out while deselected
// RQ5 - answered select line comes from board shunt, never a runtime signal
// RQ6 - controller asserts one select at most; duplicate addresses undefined
// RQ7 - controller holds select low until step or transfer finishes
// RQ8 - head-select options turn a select line into head select input
// RQ9 - step pulses arriving while deselected are discarded
// RQ10 - media-change indication clears on select rising edge when ready
// RQ11 - inputs synchronised; reset comes up deselected, outputs inactive; code can pulse selected and head one, then ctrl and status, a cycle each on release
package select_pkg;
    localparam int unsigned UNITS       = 4;
    localparam int unsigned MOTOR_LINES = 4;
    localparam int unsigned SYNC_DEPTH  = 3;

    typedef struct packed {
        logic step;
        logic direction;
        logic write_gate;
        logic side;
    } ctrl_t;

    typedef struct packed {
        logic index;
        logic track0;
        logic write_protect;
        logic read_data;
        logic ready;
        logic media_change;
    } status_t;

    localparam status_t STATUS_IDLE = '0;
endpackage

// File: logic/pin_sync.sv
/*
 three stage synchroniser for pins from outside the clock domain.
 assumes one clock; output changes once stages two and three agree.
*/
`timescale 1ns/1ps
module pin_sync
    import select_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    input  wire logic             clk_sys_in,
    input  wire logic             reset_in,
    input  wire logic [WIDTH-1:0] raw_in,
    input  wire logic [WIDTH-1:0] init_in,
    output logic      [WIDTH-1:0] clean_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
        logic [1:0]       fill;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;
    logic        primed;

    // stage three holds a real pin sample only once all stages are filled
    assign primed = (state_reg.fill == 2'(SYNC_DEPTH)); // [RQ11]

    always_comb
    begin
        state_next    = state_reg;
        state_next.s1 = raw_in;
        state_next.s2 = state_reg.s1;
        state_next.s3 = state_reg.s2;
        if (!primed)
        begin
            state_next.fill = state_reg.fill + 2'd1;
        end
        for (int i = 0; i < WIDTH; i++)
        begin
            if (state_reg.s2[i] == state_reg.s3[i])
            begin
                state_next.q[i] = state_reg.s3[i];
            end
        end
        if (!primed)
        begin
            state_next.q = init_in; // [RQ11]
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign clean_out = state_reg.q;
endmodule

// File: logic/drive_select_motor_control.sv
/*
 unit select qualifier, head select option and motor polarity of a disk drive.
 assumes pins arrive raw, select and side lines low true; drive core on the same clock.
*/
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module drive_select_motor_control
    import select_pkg::*;
(
    input  wire logic                        clk_sys_in,
    input  wire logic                        reset_in,
    input  wire logic [select_pkg::UNITS-1:0] unit_select_n_in,
    input  wire logic [select_pkg::UNITS-1:0] address_shunt_in,
    input  wire logic [select_pkg::UNITS-1:0] head_via_select_option_in,
    input  wire logic                        motor_active_low_jumper_in,
    input  wire logic                        motor_active_high_jumper_in,
    input  wire logic [select_pkg::MOTOR_LINES-1:0] motor_on_in,
    input  wire logic                        side_select_n_in,
    input  wire select_pkg::ctrl_t           ctrl_raw_in,
    input  wire select_pkg::status_t         status_core_in,
    input  wire logic                        media_changed_in,
    output select_pkg::ctrl_t                ctrl_out,
    output select_pkg::status_t              status_out,
    output logic                             selected_out,
    output logic                             head_one_out,
    output logic                             spindle_on_out,
    output logic                             media_change_out
);
    typedef struct packed {
        logic    selected;
        logic    prev_sel;
        logic    head_one;
        logic    spindle;
        logic    change;
        ctrl_t   ctrl;
        status_t status;
    } core_state_t;

    localparam int unsigned SYNC_W = UNITS + MOTOR_LINES + 1;

    core_state_t             state_reg;
    core_state_t             state_next;
    logic [SYNC_W-1:0]       sync_raw;
    logic [SYNC_W-1:0]       sync_init;
    logic [SYNC_W-1:0]       sync_q;
    logic [UNITS-1:0]        sel_low;
    logic [UNITS-1:0]        head_lines;
    logic [UNITS-1:0]        addr_hit;
    logic [MOTOR_LINES-1:0]  motor_sync;
    logic                    side_sync;
    logic                    match_low;
    logic                    motor_asserted;

    assign sync_raw  = {unit_select_n_in, motor_on_in, side_select_n_in};
    assign sync_init = {{UNITS{1'b1}}, {MOTOR_LINES{~motor_active_high_jumper_in}}, 1'b1};

    pin_sync #(.WIDTH(SYNC_W)) u_sync // [RQ11]
    (
        .clk_sys_in (clk_sys_in),
        .reset_in   (reset_in),
        .raw_in     (sync_raw),
        .init_in    (sync_init),
        .clean_out  (sync_q)
    );

    // per line: either address match or head select use
    genvar g;
    generate
        for (g = 0; g < UNITS; g++)
        begin : g_line
            assign sel_low[g]    = ~sync_q[SYNC_W-1-(UNITS-1-g)];
            assign head_lines[g] = head_via_select_option_in[g] & sel_low[g]; // [RQ8]
            assign addr_hit[g]   = address_shunt_in[g] & ~head_via_select_option_in[g]
                                   & sel_low[g]; // [RQ2] [RQ5]
        end
    endgenerate

    assign motor_sync = sync_q[MOTOR_LINES:1];
    assign side_sync  = sync_q[0];
    assign match_low  = |addr_hit; // [RQ3]

    // high jumper makes the lines high true, else low jumper low true; with neither jumper the spindle stays off
    assign motor_asserted = motor_active_high_jumper_in ? (|motor_sync)
                          : (motor_active_low_jumper_in ? ~(&motor_sync) : 1'b0); // [RQ1]

    always_comb
    begin
        state_next          = state_reg;
        state_next.selected = match_low;
        state_next.prev_sel = state_reg.selected;
        state_next.spindle  = motor_asserted; // [RQ1]
        state_next.head_one = (|head_lines) | ~side_sync; // [RQ8]
        if (state_reg.selected)
        begin
            state_next.ctrl   = ctrl_raw_in; // [RQ3]
            state_next.status = status_core_in;
        end
        else
        begin
            state_next.ctrl   = '0; // [RQ4] [RQ9]
            state_next.status = STATUS_IDLE; // [RQ4]
        end
        if (state_reg.prev_sel && !state_reg.selected && status_core_in.ready)
        begin
            state_next.change = 1'b0; // [RQ10]
        end
        if (media_changed_in)
        begin
            state_next.change = 1'b1;
        end
        state_next.status.media_change = state_reg.selected & state_reg.change;
    end

    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_reg <= '0; // [RQ11]
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign ctrl_out         = state_reg.ctrl;
    assign status_out       = state_reg.status;
    assign selected_out     = state_reg.selected;
    assign head_one_out     = state_reg.head_one;
    assign spindle_on_out   = state_reg.spindle;
    assign media_change_out = state_reg.change;

    a_step_drop_desel: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !$past(state_reg.selected) |-> !ctrl_out.step) // [RQ9]
        else $error("step passed while deselected");
    a_status_off_desel: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !$past(state_reg.selected) |-> status_out == STATUS_IDLE) // [RQ4]
        else $error("status active while deselected");
    a_select_follow: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        match_low |=> selected_out) // [RQ3]
        else $error("match did not select");
    a_select_drop: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        !match_low |=> !selected_out) // [RQ4]
        else $error("select stuck without match");
    a_head_option: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (|head_lines) |=> head_one_out) // [RQ8]
        else $error("head select option ignored");
    a_motor_polarity: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (motor_active_high_jumper_in && (|motor_sync)) |=> spindle_on_out) // [RQ1]
        else $error("motor high polarity wrong");
    a_change_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        ($fell(selected_out) && status_core_in.ready && !media_changed_in) |=> !media_change_out) // [RQ10]
        else $error("media change not cleared");
    a_shunt_only: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        ((addr_hit & ~address_shunt_in) == '0)) // [RQ5]
        else $error("unshunted line matched");
    a_reset_idle: assert property (@(posedge clk_sys_in)
        reset_in |=> (!selected_out && status_out == STATUS_IDLE)) // [RQ11]
        else $error("reset not idle");
    a_motor_low: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!motor_active_high_jumper_in && motor_active_low_jumper_in && !(&motor_sync))
        |=> spindle_on_out) // [RQ1]
        else $error("motor low polarity wrong");
    a_motor_none: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        (!motor_active_high_jumper_in && !motor_active_low_jumper_in) |=> !spindle_on_out) // [RQ1]
        else $error("motor on without jumper");
    a_ctrl_follow: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        selected_out |=> (ctrl_out == $past(ctrl_raw_in))) // [RQ3]
        else $error("controls not passed while selected");
    a_change_set: assert property (@(posedge clk_sys_in) disable iff (reset_in)
        media_changed_in |=> media_change_out) // [RQ10]
        else $error("media change not set");

    c_select: cover property (@(posedge clk_sys_in) disable iff (reset_in) $rose(selected_out));
    c_deselect: cover property (@(posedge clk_sys_in) disable iff (reset_in) $fell(selected_out));
    c_head: cover property (@(posedge clk_sys_in) disable iff (reset_in) $rose(head_one_out));
    c_spindle: cover property (@(posedge clk_sys_in) disable iff (reset_in) $rose(spindle_on_out));
    c_change: cover property (@(posedge clk_sys_in) disable iff (reset_in) $fell(media_change_out));
endmodule

// File: test/host_ctrl_model.sv
/*
 controller side model driving the four unit select lines.
 assumes the bench asks for one unit and flags a busy operation.
*/
`timescale 1ns/1ps
module host_ctrl_model
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    input  wire logic [1:0] unit_in,
    input  wire logic       sel_in,
    input  wire logic       busy_in,
    output logic      [3:0] unit_select_n_out
);
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
            unit_select_n_out <= 4'hf;
        else if (!(busy_in && unit_select_n_out != 4'hf)) // hold through operation
            unit_select_n_out <= sel_in ? ~(4'h1 << unit_in) : 4'hf; // one line low at most
    end
endmodule

// File: test/test_drive_select_motor_control.sv
/*
 self-checking bench of the select qualifier and motor polarity.
 assumes the design package and the controller model are compiled first.
*/
`timescale 1ns/1ps
`define check(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module test_drive_select_motor_control;
    import select_pkg::*;
    typedef struct packed {
        logic [3:0] sh, opt; logic [1:0] unit;
        logic sel, side_n, lo, hi, mot, e_sel, e_head, e_spin;
    } row_t;
    logic clk = 0, rst = 1, sel = 0, lo = 0, hi = 0, side_n = 1, mchg = 0;
    logic [1:0] unit = 0;
    logic [3:0] sh = 4'h1, opt = 4'h0, mot = 4'h0, sel_n;
    ctrl_t ctrl = '0, ctrl_o;
    status_t st = 6'h2a, st_o;
    logic s_o, h_o, sp_o, m_o;
    int fail_count = 0, comparisons = 0;
    row_t rows [9] = '{
        '{4'h1, 4'h0, 2'd0, 1, 1, 1, 0, 0, 1, 0, 1}, '{4'h1, 4'h0, 2'd0, 1, 1, 1, 0, 1, 1, 0, 0},
        '{4'h1, 4'h0, 2'd0, 1, 0, 0, 1, 1, 1, 1, 1}, '{4'h1, 4'h0, 2'd0, 1, 1, 1, 1, 1, 1, 0, 1},
        '{4'h2, 4'h0, 2'd0, 1, 1, 0, 0, 0, 0, 0, 0}, '{4'h2, 4'h0, 2'd1, 1, 1, 0, 0, 0, 1, 0, 0},
        '{4'h8, 4'h0, 2'd3, 1, 1, 0, 0, 0, 1, 0, 0}, '{4'h1, 4'h4, 2'd2, 1, 1, 0, 0, 0, 0, 1, 0},
        '{4'h1, 4'h0, 2'd0, 0, 1, 0, 0, 0, 0, 0, 0}};
    always #5 clk = ~clk;
    host_ctrl_model model (.clk_sys_in(clk), .reset_in(rst), .unit_in(unit), .sel_in(sel),
        .busy_in(ctrl.step | ctrl.write_gate), .unit_select_n_out(sel_n));
    drive_select_motor_control dut (.clk_sys_in(clk), .reset_in(rst), .unit_select_n_in(sel_n),
        .address_shunt_in(sh), .head_via_select_option_in(opt), .motor_active_low_jumper_in(lo),
        .motor_active_high_jumper_in(hi), .motor_on_in(mot), .side_select_n_in(side_n),
        .ctrl_raw_in(ctrl), .status_core_in(st), .media_changed_in(mchg), .ctrl_out(ctrl_o),
        .status_out(st_o), .selected_out(s_o), .head_one_out(h_o), .spindle_on_out(sp_o),
        .media_change_out(m_o));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #50000;
        fail_count++;
        stop_test();
    end
    initial
    begin
        tick(2);
        `check({s_o, ctrl_o, st_o, m_o}, 12'h000)
        tick(3);
        rst <= 0;
        foreach (rows[i])
        begin
            @(posedge clk);
            {sh, opt, unit, sel, side_n, lo, hi} <= rows[i][17:4];
            mot <= {4{rows[i].mot}};
            tick(8);
            `check({s_o, h_o, sp_o}, {rows[i].e_sel, rows[i].e_head, rows[i].e_spin})
        end
        @(posedge clk);
        {sh, opt, unit, sel, side_n} <= {4'h1, 4'h0, 2'd0, 1'b1, 1'b1};
        ctrl <= 4'ha;
        tick(2);
        `check(s_o, 1'b0)
        tick(6);
        `check({s_o, ctrl_o, st_o}, 11'h6aa)
        @(posedge clk);
        ctrl <= 4'h0;
        sel <= 0;
        tick(2);
        ctrl <= 4'h8;
        tick(8);
        `check({s_o, ctrl_o, st_o}, 11'h000)
        mchg <= 1;
        tick(1);
        mchg <= 0;
        st <= 6'h28;
        sel <= 1;
        ctrl <= 4'h0;
        tick(8);
        `check({m_o, st_o}, 7'h69)
        sel <= 0;
        tick(8);
        `check(m_o, 1'b1)
        st <= 6'h2a;
        sel <= 1;
        tick(8);
        sel <= 0;
        tick(8);
        `check(m_o, 1'b0)
        rst <= 1;
        tick(2);
        `check({s_o, h_o, sp_o, ctrl_o, st_o, m_o}, 14'h0)
        rst <= 0;
        tick(3);
        `check({s_o, h_o, st_o}, 8'h00)
        tick(3);
        `check({s_o, h_o, st_o}, 8'h00)
        stop_test();
    end
endmodule
